// ---- logic/xbus_pkg.sv ----
// Purpose: Shared constants and types for the buffered expansion bus.
// Assumes: 50 MHz sys_clk, one clock domain.
// Notes:   Bus cycle phase counts are in sys_clk cycles.
package xbus_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int LOW_W  = 8;    // Multiplexed address/data width
   localparam int HIGH_W = 12;   // High address width, bits 8..19
   localparam int ADDR_W = 20;   // Full address width
   localparam int LOW_LSB  = 0;  // Low address field position
   localparam int HIGH_LSB = 8;  // High address field position
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS      = 20;   // sys_clk period
   localparam int T_ALE_NS    = 40;   // Least address latch strobe width
   localparam int ALE_CYC     = (T_ALE_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_STROBE_NS = 80;   // Least read/write strobe width
   localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W       = 4;    // Phase counter width
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [LOW_W-1:0]  LOW_RST  = 8'h00;
   localparam logic [HIGH_W-1:0] HIGH_RST = 12'h000;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_END} bus_state_t;
endpackage

// ---- logic/ack_sync_if.sv ----
// Purpose: Carrier between the bus top and the acknowledge synchroniser.
// Assumes: One clock domain.
// Notes:   raw in, synchronised level out.
`timescale 1ns/100ps
interface ack_sync_if;
   logic raw;    // Pin level as it arrives
   logic synced; // Resynchronised level
   modport sync (input raw, output synced);
   modport user (output raw, input synced);
endinterface

// ---- logic/ack_sync.sv ----
// Purpose: Two-stage resynchroniser for the external acknowledge pin.
// Assumes: Pin idles high.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/100ps
module ack_sync (
   input  wire logic  sys_clk, // System clock
   input  wire logic  arst_n,  // Async reset, active low
   ack_sync_if.sync   port_if  // Raw in, synced out
);
   // ----------------------------------------
   // Synchroniser stages
   // ----------------------------------------
   logic stage1;      // First flop
   logic stage2;      // Second flop
   logic next_stage1; // Next first flop
   logic next_stage2; // Next second flop

   // Next values
   always_comb begin
      next_stage1 = port_if.raw;
      next_stage2 = stage1;
   end

   // Register, idle high from reset
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1 <= 1'b1;
         stage2 <= 1'b1;
      end else begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
      end
   end

   assign port_if.synced = stage2;
endmodule // ack_sync

// ---- logic/buffered_expansion_bus.sv ----
// Purpose: Drives the buffered expansion bus for one processor access.
// Assumes: Requests arrive synchronous to sys_clk; req_go pulses while idle.
// Notes:   Bus is released to an external master on hold; no buffering.
`timescale 1ns/100ps
// How it works
// - Eight-bit muxed bus plus twelve-bit high address
// - High address valid from ALE rise onward
// - High address tri-stated while bus granted
// - Low address on muxed lines while ALE is high, replaced on the edge where ALE falls
// - Address latch strobe marks valid low address
// - Read strobe marks read cycles
// - Write strobe marks write cycles
// - Grant tri-states outputs; external capture strobe
// - Acknowledge idles high, low inserts waits, resynchronised
module buffered_expansion_bus #(
   parameter int ALE_CYC    = xbus_pkg::ALE_CYC,    // Latch strobe width
   parameter int STROBE_CYC = xbus_pkg::STROBE_CYC  // Least strobe width
) (
   input  wire logic                          sys_clk,         // System clock
   input  wire logic                          arst_n,          // Async reset, active low
   input  wire logic                          req_go,          // Start access, pulse
   input  wire logic                          req_write,       // 1 write, 0 read
   input  wire logic                          req_io,          // 1 I/O, 0 memory
   input  wire logic [xbus_pkg::ADDR_W-1:0]   req_addr,        // Access address
   input  wire logic [xbus_pkg::LOW_W-1:0]    req_wdata,       // Write data
   output logic                               req_busy,        // Access in progress
   output logic                               req_done,        // Access finished, pulse
   output logic [xbus_pkg::LOW_W-1:0]         req_rdata,       // Read data
   input  wire logic                          hold_req,        // External master request
   output logic                               bus_grant,       // Bus handed over
   output logic [xbus_pkg::HIGH_W-1:0]        high_addr_o,     // High address out
   output logic                               high_addr_oe,    // High address drive
   input  wire logic [xbus_pkg::HIGH_W-1:0]   high_addr_i,     // High address in
   output logic [xbus_pkg::LOW_W-1:0]         mux_addr_data_o, // Muxed lines out
   output logic                               mux_addr_data_oe,// Muxed lines drive
   input  wire logic [xbus_pkg::LOW_W-1:0]    mux_addr_data_i, // Muxed lines in
   output logic                               ale,             // Address latch strobe
   output logic                               rd_n,            // Read strobe, low active
   output logic                               wr_n,            // Write strobe, low active
   output logic                               den_n,           // Data enable, low active
   output logic                               io_m,            // I/O or memory status
   output logic                               ctrl_oe,         // Strobe and status drive
   output logic                               data_capture_strobe_o,  // Capture strobe out
   output logic                               data_capture_strobe_oe, // Capture strobe drive
   input  wire logic                          ext_ack,         // External acknowledge
   output logic                               ready            // Synced ready status
);
   // ----------------------------------------
   // Acknowledge resynchroniser
   // ----------------------------------------
   ack_sync_if ack_if ();                 // Carrier to synchroniser
   assign ack_if.raw = ext_ack;
   ack_sync u_ack_sync (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .port_if (ack_if)
   );
   assign ready = ack_if.synced;

   // ----------------------------------------
   // State
   // ----------------------------------------
   xbus_pkg::bus_state_t             state;       // Cycle phase
   xbus_pkg::bus_state_t             next_state;
   logic [xbus_pkg::CNT_W-1:0]       cnt;         // Phase counter
   logic [xbus_pkg::CNT_W-1:0]       next_cnt;
   logic                             is_write;    // Latched direction
   logic                             next_is_write;
   logic                             is_io;       // Latched space
   logic                             next_is_io;
   logic [xbus_pkg::ADDR_W-1:0]      addr;        // Latched address
   logic [xbus_pkg::ADDR_W-1:0]      next_addr;
   logic [xbus_pkg::LOW_W-1:0]       wdata;       // Latched write data
   logic [xbus_pkg::LOW_W-1:0]       next_wdata;
   logic [xbus_pkg::LOW_W-1:0]       rdata;       // Captured read data
   logic [xbus_pkg::LOW_W-1:0]       next_rdata;
   logic                             grant;       // Bus handed over
   logic                             next_grant;
   logic                             done;        // Done pulse
   logic                             next_done;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      next_state    = state;
      next_cnt      = cnt;
      next_is_write = is_write;
      next_is_io    = is_io;
      next_addr     = addr;
      next_wdata    = wdata;
      next_rdata    = rdata;
      next_grant    = grant;
      next_done     = 1'b0;
      unique case (state)
         xbus_pkg::ST_IDLE: begin
            // Hand over only between cycles
            if (hold_req) begin
               next_grant = 1'b1;
            end else if (grant) begin
               next_grant = 1'b0;
            end else if (req_go) begin
               next_state    = xbus_pkg::ST_ADDR;
               next_cnt      = '0;
               next_is_write = req_write;
               next_is_io    = req_io;
               next_addr     = req_addr;
               next_wdata    = req_wdata;
            end
         end
         xbus_pkg::ST_ADDR: begin
            // Latch strobe high for its width
            if (cnt == xbus_pkg::CNT_W'(ALE_CYC - 1)) begin
               next_state = xbus_pkg::ST_DATA;
               next_cnt   = '0;
            end else begin
               next_cnt = cnt + 4'h1;
            end
         end
         xbus_pkg::ST_DATA: begin
            // Strobe held; low acknowledge stretches it
            if (cnt != xbus_pkg::CNT_W'(STROBE_CYC - 1)) begin
               next_cnt = cnt + 4'h1;
            end else if (ack_if.synced) begin
               next_state = xbus_pkg::ST_END;
               if (!is_write) begin
                  next_rdata = mux_addr_data_i;
               end
            end
         end
         xbus_pkg::ST_END: begin
            // Strobes off, high address still held
            next_state = xbus_pkg::ST_IDLE;
            next_done  = 1'b1;
         end
      endcase
   end

   // Register state
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state    <= xbus_pkg::ST_IDLE;
         cnt      <= '0;
         is_write <= 1'b0;
         is_io    <= 1'b0;
         addr     <= '0;
         wdata    <= xbus_pkg::LOW_RST;
         rdata    <= xbus_pkg::LOW_RST;
         grant    <= 1'b0;
         done     <= 1'b0;
      end else begin
         state    <= next_state;
         cnt      <= next_cnt;
         is_write <= next_is_write;
         is_io    <= next_is_io;
         addr     <= next_addr;
         wdata    <= next_wdata;
         rdata    <= next_rdata;
         grant    <= next_grant;
         done     <= next_done;
      end
   end

   // ----------------------------------------
   // Output drivers
   // ----------------------------------------
   logic in_data;   // Data phase
   assign in_data = (state == xbus_pkg::ST_DATA);

   // High address held from latch phase until next cycle
   assign high_addr_o  = addr[xbus_pkg::HIGH_LSB +: xbus_pkg::HIGH_W];
   assign high_addr_oe = !grant;
   // Low address during latch phase, write data later
   assign mux_addr_data_o = (state == xbus_pkg::ST_ADDR) ?
                            addr[xbus_pkg::LOW_LSB +: xbus_pkg::LOW_W] : wdata;
   assign mux_addr_data_oe = !grant && ((state == xbus_pkg::ST_ADDR) || (in_data && is_write));
   assign ale      = (state == xbus_pkg::ST_ADDR);
   assign rd_n     = !(in_data && !is_write);
   assign wr_n     = !(in_data && is_write);
   assign den_n    = !in_data;
   assign io_m     = is_io;
   assign ctrl_oe  = !grant;
   // Capture strobe falls at read end; external logic owns it in grant
   assign data_capture_strobe_o  = in_data && !is_write;
   assign data_capture_strobe_oe = !grant;
   assign bus_grant = grant;
   assign req_busy  = (state != xbus_pkg::ST_IDLE) || grant;
   assign req_done  = done;
   assign req_rdata = rdata;
   // High address input only meaningful in grant; folded into unused_high, read nowhere
   logic unused_high; // Unused
   assign unused_high = ^high_addr_i;
endmodule // buffered_expansion_bus

// ---- dv/xbus_chk.sv ----
// Purpose: Pin-level protocol checks on the expansion bus top
// Assumes: One clock, async active-low reset
// Notes:   Bound to every bus top instance
`timescale 1ns/100ps
module xbus_chk #(
   parameter int ALE_CYC    = xbus_pkg::ALE_CYC,    // Latch strobe width
   parameter int STROBE_CYC = xbus_pkg::STROBE_CYC  // Least strobe width
) (
   input wire logic                        sys_clk,                // System clock
   input wire logic                        arst_n,                 // Async reset, active low
   input wire logic                        req_go,                 // Start access
   input wire logic                        req_write,              // Write request
   input wire logic                        req_busy,               // Access running
   input wire logic                        req_done,               // Access finished
   input wire logic                        hold_req,               // External master request
   input wire logic                        bus_grant,              // Bus handed over
   input wire logic                        high_addr_oe,           // High address drive
   input wire logic                        mux_addr_data_oe,       // Muxed lines drive
   input wire logic                        ale,                    // Address latch strobe
   input wire logic                        rd_n,                   // Read strobe
   input wire logic                        wr_n,                   // Write strobe
   input wire logic                        den_n,                  // Data enable
   input wire logic                        ctrl_oe,                // Strobe and status drive
   input wire logic                        data_capture_strobe_o,  // Capture strobe
   input wire logic                        data_capture_strobe_oe, // Capture strobe drive
   input wire logic                        ready,                  // Synced ready
   input wire logic                        ext_ack,                // External acknowledge
   input wire logic [xbus_pkg::HIGH_W-1:0] high_addr_o,            // High address
   input wire logic [xbus_pkg::LOW_W-1:0]  mux_addr_data_o         // Muxed lines
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------
   // Strobe low-cycle counter
   // ----------------------------------------
   logic [3:0] strb_cnt, next_strb_cnt; // Cycles with a strobe low
   always_comb next_strb_cnt = (rd_n && wr_n) ? 4'h0 : strb_cnt + 4'h1;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) strb_cnt <= 4'h0;
      else strb_cnt <= next_strb_cnt;
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   hi_hold_a: assert property (!ale |-> $stable(high_addr_o))
      else $error("high address moved outside latch strobe");
   grant_off_a: assert property (bus_grant |-> !(high_addr_oe || mux_addr_data_oe || ctrl_oe || data_capture_strobe_oe))
      else $error("driver left on while granted");
   drive_on_a: assert property (!bus_grant |-> high_addr_oe && ctrl_oe && data_capture_strobe_oe)
      else $error("driver off while not granted");
   ale_mux_a: assert property (ale && $past(ale) |-> $stable(mux_addr_data_o) && mux_addr_data_oe)
      else $error("muxed address not held during latch strobe");
   ale_width_a: assert property ($rose(ale) |-> ale ##1 ale ##1 !ale)
      else $error("latch strobe width wrong");
   rd_start_a: assert property (req_go && !req_busy && !hold_req && !bus_grant && !req_write |-> ##3 !rd_n && wr_n && !den_n && data_capture_strobe_o)
      else $error("read strobe missing");
   wr_start_a: assert property (req_go && !req_busy && !hold_req && !bus_grant && req_write |-> ##3 !wr_n && rd_n && !data_capture_strobe_o)
      else $error("write strobe missing");
   strb_width_a: assert property ($rose(rd_n && wr_n) |-> strb_cnt >= STROBE_CYC ##1 req_done ##1 !req_done)
      else $error("strobe too short or done misplaced");
   ack_sync_a: assert property (ready == $past(ext_ack, 2))
      else $error("ready not resynchronised acknowledge");
   wait_ext_a: assert property (!ready && !rd_n |=> !rd_n)
      else $error("strobe ended while not ready");
   grant_take_a: assert property (hold_req && !req_busy |=> bus_grant)
      else $error("hold not granted");
   grant_drop_a: assert property (bus_grant && !hold_req |=> !bus_grant)
      else $error("grant kept after hold dropped");
   // Main scenarios
   rd_c: cover property (!rd_n ##1 rd_n);
   wr_c: cover property (!wr_n ##1 wr_n);
   wait_c: cover property (!rd_n && !ready);
   grant_c: cover property (bus_grant);
endmodule // xbus_chk
bind buffered_expansion_bus xbus_chk #(
   .ALE_CYC    (ALE_CYC),
   .STROBE_CYC (STROBE_CYC)
) chk (
   .sys_clk (sys_clk), .arst_n (arst_n), .req_go (req_go), .req_write (req_write),
   .req_busy (req_busy), .req_done (req_done), .hold_req (hold_req), .bus_grant (bus_grant),
   .high_addr_oe (high_addr_oe), .mux_addr_data_oe (mux_addr_data_oe), .ale (ale),
   .rd_n (rd_n), .wr_n (wr_n), .den_n (den_n), .ctrl_oe (ctrl_oe),
   .data_capture_strobe_o (data_capture_strobe_o), .data_capture_strobe_oe (data_capture_strobe_oe),
   .ready (ready), .ext_ack (ext_ack), .high_addr_o (high_addr_o), .mux_addr_data_o (mux_addr_data_o)
);

// ---- dv/xcard.sv ----
// Purpose: Add-in card model answering reads and inserting waits
// Assumes: Strobes are active low
// Notes:   Released data lines show the inverse of the last byte
`timescale 1ns/100ps
module xcard (
   input  wire logic       sys_clk,         // System clock
   input  wire logic       rd_n,            // Read strobe
   input  wire logic       wr_n,            // Write strobe
   input  wire logic [3:0] waits,           // Wait cycles to insert
   input  wire logic [7:0] rd_byte,         // Byte to return
   output logic      [7:0] mux_addr_data_i, // Data toward the bus
   output logic            ext_ack          // Acknowledge, idle high
);
   logic [3:0] cnt  = 4'h0;  // Strobe age
   logic [7:0] last = 8'h00; // Last byte driven
   always @(posedge sys_clk) cnt <= (rd_n && wr_n) ? 4'h0 : (cnt == 4'hF) ? cnt : cnt + 4'h1;
   always @(posedge sys_clk) if (!rd_n) last <= rd_byte;
   assign ext_ack = !(!(rd_n && wr_n) && cnt < waits);
   assign mux_addr_data_i = !rd_n ? rd_byte : ~last;
endmodule // xcard

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the expansion bus top
// Assumes: Card model answers reads and may insert waits
// Notes:   Inputs move 1 ns after the rising edge
`timescale 1ns/100ps
module tb;
   logic sys_clk = 1'b0, arst_n = 1'b0, req_go = 1'b0, req_write = 1'b0, req_io = 1'b0;
   logic hold_req = 1'b0, req_busy, req_done, bus_grant, high_addr_oe, mux_addr_data_oe, ale, rd_n;
   logic wr_n, den_n, io_m, ctrl_oe, data_capture_strobe_o, data_capture_strobe_oe, ext_ack, ready;
   logic [19:0] req_addr = 20'h00000;
   logic [7:0]  req_wdata = 8'h00, rd_byte = 8'h00, req_rdata, mux_addr_data_o, mux_addr_data_i;
   logic [11:0] high_addr_o, high_addr_i = 12'h000;
   logic [3:0]  waits = 4'h0;
   int          n_fail = 0, checked = 0, tcnt = 0, n, sc;
   buffered_expansion_bus dut (.*);
   xcard card (.sys_clk, .rd_n, .wr_n, .waits, .rd_byte, .mux_addr_data_i, .ext_ack);
   initial forever #10 sys_clk = ~sys_clk;
   task automatic tally_and_finish;
      $display("Counts: checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      tcnt++;
      if (tcnt == 3000) begin
         n_fail++;
         tally_and_finish;
      end
   end
   task automatic chk(input logic [19:0] e, input logic [19:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // One access, counting edges to done and strobe cycles
   task automatic access(input logic w, input logic [19:0] a, input logic [7:0] d);
      req_write = w;
      req_io = w;
      req_addr = a;
      req_wdata = d;
      req_go = 1'b1;
      n = 0;
      sc = 0;
      do begin
         @(posedge sys_clk);
         #1;
         req_go = 1'b0;
         n++;
         if (ale === 1'b1) chk(a[7:0], mux_addr_data_o);
         if (ale === 1'b1) chk(w, io_m);
         if ((w ? wr_n : rd_n) === 1'b0) sc++;
         if (w && wr_n === 1'b0) chk(d, mux_addr_data_o);
      end while (req_done !== 1'b1 && n < 40);
      chk(1'b1, req_done);
      chk(1'b0, req_busy);
      chk(a[19:8], high_addr_o);
   endtask
   task automatic sc_back2back;
      rd_byte = 8'h5A;
      access(1'b0, 20'hA5C3E, 8'h00);
      chk(8'h5A, req_rdata);
      chk(20'(xbus_pkg::ALE_CYC + xbus_pkg::STROBE_CYC + 2), 20'(n));
      chk(20'(xbus_pkg::STROBE_CYC), 20'(sc));
      access(1'b1, 20'hFFFFF, 8'hC6);
      chk(20'(xbus_pkg::STROBE_CYC), 20'(sc));
      rd_byte = 8'h96;
      access(1'b0, 20'h00000, 8'h00);
      chk(20'(xbus_pkg::ALE_CYC + xbus_pkg::STROBE_CYC + 2), 20'(n));
      chk(8'h96, req_rdata);
      $display("test back2back done");
   endtask
   task automatic sc_wait;
      waits = 4'h6;
      rd_byte = 8'h3C;
      access(1'b0, 20'h12345, 8'h00);
      chk(1'b1, sc > xbus_pkg::STROBE_CYC);
      chk(8'h3C, req_rdata);
      waits = 4'h0;
      $display("test wait done");
   endtask
   task automatic sc_hold;
      hold_req = 1'b1;
      @(posedge sys_clk);
      #1;
      chk(1'b1, bus_grant);
      chk(4'h0, {high_addr_oe, mux_addr_data_oe, ctrl_oe, data_capture_strobe_oe});
      req_go = 1'b1;
      high_addr_i = 12'h5A5;
      @(posedge sys_clk);
      #1;
      req_go = 1'b0;
      chk(1'b0, ale);
      high_addr_i = 12'h000;
      @(posedge sys_clk);
      #1;
      chk(1'b1, bus_grant);
      hold_req = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(1'b0, bus_grant);
      chk(4'hB, {high_addr_oe, mux_addr_data_oe, ctrl_oe, data_capture_strobe_oe});
      $display("test hold done");
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      @(posedge sys_clk);
      #1;
      sc_back2back;
      sc_wait;
      sc_hold;
      tally_and_finish;
   end
endmodule // tb
